/* File: rtl/cts_pkg.sv */
// Package with register layout, reset values and carriers for the core thermal status block
package cts_pkg;

   // Register indices on the register port
   localparam logic [0:0] CTS_IDX_STATUS  = 1'h0;
   localparam logic [0:0] CTS_IDX_CONTROL = 1'h1;

   // Status field positions
   localparam int CTS_ST_HOT       = 0;
   localparam int CTS_ST_HOT_LOG   = 1;
   localparam int CTS_ST_EXT       = 2;
   localparam int CTS_ST_EXT_LOG   = 3;
   localparam int CTS_ST_CRIT      = 4;
   localparam int CTS_ST_CRIT_LOG  = 5;
   localparam int CTS_ST_THR1      = 6;
   localparam int CTS_ST_THR1_LOG  = 7;
   localparam int CTS_ST_THR2      = 8;
   localparam int CTS_ST_THR2_LOG  = 9;
   localparam int CTS_ST_PWR       = 10;
   localparam int CTS_ST_PWR_LOG   = 11;
   localparam int CTS_ST_READ_LSB  = 16;
   localparam int CTS_ST_RES_LSB   = 27;
   localparam int CTS_ST_VALID     = 31;

   // Control field positions
   localparam int CTS_CT_HI_EN     = 0;
   localparam int CTS_CT_LO_EN     = 1;
   localparam int CTS_CT_EXTHOT_EN = 2;
   localparam int CTS_CT_FPR_EN    = 3;
   localparam int CTS_CT_CRIT_EN   = 4;
   localparam int CTS_CT_THR1_LSB  = 8;
   localparam int CTS_CT_THR1_EN   = 15;
   localparam int CTS_CT_THR2_LSB  = 16;
   localparam int CTS_CT_THR2_EN   = 23;
   localparam int CTS_CT_PLN_EN    = 24;

   // Sticky log bit mask and control writable mask
   localparam logic [31:0] CTS_LOG_MASK   = 32'h0000_0aaa;
   localparam logic [31:0] CTS_CTRL_MASK  = 32'h01ff_ff1f;
   localparam logic [31:0] CTS_CTRL_RESET = 32'h0000_0000;
   localparam logic [11:0] CTS_LOG_RESET  = 12'h000;
   localparam logic [6:0]  CTS_READ_RESET = 7'h00;

   // Samples taken from the sensor and platform pins
   typedef struct packed {
      logic       hot;
      logic       ext_hot;
      logic       forced_power_reduction_input;
      logic       crit;
      logic       below_req;
      logic       valid;
      logic [6:0] readout;
   } cts_sense_t;

   // Register port request
   typedef struct packed {
      logic        wr;
      logic [0:0]  idx;
      logic [31:0] wdata;
   } cts_req_t;

endpackage : cts_pkg

/* File: rtl/cts_sync.sv */
// Two-flop synchroniser bank for asynchronous sensor and pin inputs
`timescale 1ns/1ps
module cts_sync
   import cts_pkg::*;
#(
   parameter int W = 13
) (
   input  wire logic         i_sys_clk,
   input  wire logic         i_rst_n,
   input  wire logic         i_ce,
   input  wire logic [W-1:0] i_async,
   output logic      [W-1:0] o_sync
);
   logic [W-1:0] meta_reg;

   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         meta_reg <= '0;
         o_sync   <= '0;
      end else if (i_ce) begin
         meta_reg <= i_async;
         o_sync   <= meta_reg;
      end
   end
endmodule : cts_sync

/* File: rtl/cts_core.sv */
// Per-core thermal sensor status and interrupt-control registers
`timescale 1ns/1ps
module cts_core
   import cts_pkg::*;
#(
   parameter logic       PWR_NOTIFY_SUPPORTED = 1'b1,
   parameter logic [3:0] SENSOR_RESOLUTION    = 4'h1
) (
   input  wire logic        i_sys_clk,
   input  wire logic        i_rst_n,
   input  wire logic        i_ce,
   input  wire logic        i_hot,
   input  wire logic        i_ext_hot,
   input  wire logic        i_forced_power_reduction_input,
   input  wire logic        i_bidir_hot_en,
   input  wire logic        i_crit,
   input  wire logic        i_below_req,
   input  wire logic        i_readout_valid,
   input  wire logic [6:0]  i_readout,
   input  wire logic        i_req_valid,
   input  wire logic        i_req_wr,
   input  wire logic        i_req_idx,
   input  wire logic [31:0] i_req_wdata,
   output logic      [31:0] o_rdata,
   output logic             o_rvalid,
   output logic             o_thermal_irq
);

   localparam int SW = $bits(cts_sense_t);

   cts_sense_t sense_raw;
   cts_sense_t sense;
   cts_sense_t prev_reg;
   cts_req_t   req;
   logic [SW-1:0] sense_bits;
   logic          bidir_meta_reg;
   logic          bidir_reg;
   cts_sense_t    sense_f;
   logic [7:0]    rd_last_reg;
   logic [7:0]    rd_hold_reg;

   logic [31:0] ctrl_reg;
   logic [11:0] log_reg;
   logic [11:0] log_next;
   logic [11:0] cur;
   logic [11:0] prev_cur;
   logic [31:0] status;
   logic        irq_next;
   logic        status_wr;

   // Readout at or below a threshold means a hotter-or-equal reading
   function automatic logic at_or_above(input logic [6:0] rd, input logic [6:0] thr);
      at_or_above = (rd <= thr);
   endfunction : at_or_above

   // Current-state view of the status low bits, logs left zero
   function automatic logic [11:0] cur_bits(input cts_sense_t s, input logic [31:0] c,
                                            input logic bidir);
      logic [11:0] v;
      v = '0;
      v[CTS_ST_HOT]  = s.hot;
      v[CTS_ST_EXT]  = (s.ext_hot & bidir) | s.forced_power_reduction_input;
      v[CTS_ST_CRIT] = s.crit;
      v[CTS_ST_THR1] = s.valid & at_or_above(s.readout, c[CTS_CT_THR1_LSB +: 7]);
      v[CTS_ST_THR2] = s.valid & at_or_above(s.readout, c[CTS_CT_THR2_LSB +: 7]);
      v[CTS_ST_PWR]  = s.below_req & PWR_NOTIFY_SUPPORTED;
      cur_bits = v;
   endfunction : cur_bits

   assign sense_raw = '{hot: i_hot, ext_hot: i_ext_hot,
                        forced_power_reduction_input: i_forced_power_reduction_input,
                        crit: i_crit, below_req: i_below_req, valid: i_readout_valid,
                        readout: i_readout};
   assign req = '{wr: i_req_wr, idx: i_req_idx, wdata: i_req_wdata};

   cts_sync #(.W(SW)) u_sync (
      .i_sys_clk (i_sys_clk),
      .i_rst_n   (i_rst_n),
      .i_ce      (i_ce),
      .i_async   (sense_raw),
      .o_sync    (sense_bits)
   );
   assign sense = cts_sense_t'(sense_bits);

   // Strap-like bidirectional hot enable also arrives from outside
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         bidir_meta_reg <= 1'b0;
         bidir_reg      <= 1'b0;
      end else if (i_ce) begin
         bidir_meta_reg <= i_bidir_hot_en;
         bidir_reg      <= bidir_meta_reg;
      end
   end

   // Readout word is taken only once two synced samples agree, so a word caught
   // mid-change in the per-bit synchronisers never reaches status or thresholds
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rd_last_reg <= {1'b0, CTS_READ_RESET};
         rd_hold_reg <= {1'b0, CTS_READ_RESET};
      end else if (i_ce) begin
         rd_last_reg <= {sense.valid, sense.readout};
         if ({sense.valid, sense.readout} == rd_last_reg) begin
            rd_hold_reg <= rd_last_reg;
         end
      end
   end

   always_comb begin
      sense_f         = sense;
      sense_f.valid   = rd_hold_reg[7];
      sense_f.readout = rd_hold_reg[6:0];
   end

   assign cur       = cur_bits(sense_f, ctrl_reg, bidir_reg);
   assign prev_cur  = cur_bits(prev_reg, ctrl_reg, bidir_reg);
   assign status_wr = i_req_valid && req.wr && (req.idx == CTS_IDX_STATUS);

   assign status = {sense_f.valid,
                    SENSOR_RESOLUTION,
                    4'h0,
                    sense_f.valid ? sense_f.readout : CTS_READ_RESET,
                    4'h0,
                    (cur & ~CTS_LOG_MASK[11:0]) | log_reg};

   // Control register: reserved bits stay zero
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         ctrl_reg <= CTS_CTRL_RESET;
      end else if (i_ce && i_req_valid && req.wr && (req.idx == CTS_IDX_CONTROL)) begin
         ctrl_reg <= req.wdata & CTS_CTRL_MASK;
      end
   end

   // Sticky logs: set wins over a same-cycle zero-write clear
   always_comb begin
      log_next = log_reg;
      if (status_wr) begin
         log_next = log_reg & (req.wdata[11:0] | ~CTS_LOG_MASK[11:0]);
      end
      log_next[CTS_ST_HOT_LOG]  = log_next[CTS_ST_HOT_LOG]  | cur[CTS_ST_HOT];
      log_next[CTS_ST_EXT_LOG]  = log_next[CTS_ST_EXT_LOG]  | cur[CTS_ST_EXT];
      log_next[CTS_ST_CRIT_LOG] = log_next[CTS_ST_CRIT_LOG] | cur[CTS_ST_CRIT];
      log_next[CTS_ST_THR1_LOG] = log_next[CTS_ST_THR1_LOG] | cur[CTS_ST_THR1];
      log_next[CTS_ST_THR2_LOG] = log_next[CTS_ST_THR2_LOG] | cur[CTS_ST_THR2];
      log_next[CTS_ST_PWR_LOG]  = log_next[CTS_ST_PWR_LOG]  | cur[CTS_ST_PWR];
      log_next = log_next & CTS_LOG_MASK[11:0];
   end

   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         log_reg <= CTS_LOG_RESET;
      end else if (i_ce) begin
         log_reg <= log_next;
      end
   end

   // Previous sample for edge detection of interrupt events
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         prev_reg <= '0;
      end else if (i_ce) begin
         prev_reg <= sense_f;
      end
   end

   // Event combining onto the single thermal interrupt
   always_comb begin
      irq_next = 1'b0;
      if (ctrl_reg[CTS_CT_HI_EN] && cur[CTS_ST_HOT] && !prev_cur[CTS_ST_HOT]) begin
         irq_next = 1'b1;
      end
      if (ctrl_reg[CTS_CT_LO_EN] && !cur[CTS_ST_HOT] && prev_cur[CTS_ST_HOT]) begin
         irq_next = 1'b1;
      end
      if (ctrl_reg[CTS_CT_EXTHOT_EN] && bidir_reg && sense.ext_hot && !prev_reg.ext_hot) begin
         irq_next = 1'b1;
      end
      if (ctrl_reg[CTS_CT_FPR_EN] && sense.forced_power_reduction_input
          && !prev_reg.forced_power_reduction_input) begin
         irq_next = 1'b1;
      end
      if (ctrl_reg[CTS_CT_CRIT_EN] && cur[CTS_ST_CRIT] && !prev_cur[CTS_ST_CRIT]) begin
         irq_next = 1'b1;
      end
      if (ctrl_reg[CTS_CT_THR1_EN] && (cur[CTS_ST_THR1] != prev_cur[CTS_ST_THR1])) begin
         irq_next = 1'b1;
      end
      if (ctrl_reg[CTS_CT_THR2_EN] && (cur[CTS_ST_THR2] != prev_cur[CTS_ST_THR2])) begin
         irq_next = 1'b1;
      end
      if (PWR_NOTIFY_SUPPORTED && ctrl_reg[CTS_CT_PLN_EN]
          && cur[CTS_ST_PWR] && !prev_cur[CTS_ST_PWR]) begin
         irq_next = 1'b1;
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_thermal_irq <= 1'b0;
      end else if (i_ce) begin
         o_thermal_irq <= irq_next;
      end
   end

   // Register read port, answered one cycle after the request
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_rdata  <= '0;
         o_rvalid <= 1'b0;
      end else if (i_ce) begin
         o_rvalid <= i_req_valid;
         if (i_req_valid && !req.wr) begin
            o_rdata <= (req.idx == CTS_IDX_STATUS) ? status : ctrl_reg;
         end
      end
   end

endmodule : cts_core

/* File: sim/cts_agent.sv */
// Platform agent model driving the sensor and pin levels
`timescale 1ns/1ps
module cts_agent
   import cts_pkg::*;
(
   input  wire logic       i_sys_clk,
   input  wire cts_sense_t i_cmd,
   output cts_sense_t      o_pins
);
   // Levels move only after a falling edge, then hold until commanded again
   always @(negedge i_sys_clk) o_pins <= i_cmd;
endmodule : cts_agent

/* File: sim/cts_core_sva.sv */
// Checker for the core thermal status register port
`timescale 1ns/1ps
module cts_core_sva
   import cts_pkg::*;
#(
   parameter logic       PWR_NOTIFY_SUPPORTED = 1'b1,
   parameter logic [3:0] SENSOR_RESOLUTION    = 4'h1
) (
   input wire logic        i_sys_clk,
   input wire logic        i_rst_n,
   input wire logic        i_ce,
   input wire logic        i_hot,
   input wire logic        i_ext_hot,
   input wire logic        i_forced_power_reduction_input,
   input wire logic        i_bidir_hot_en,
   input wire logic        i_crit,
   input wire logic        i_below_req,
   input wire logic        i_readout_valid,
   input wire logic [6:0]  i_readout,
   input wire logic        i_req_valid,
   input wire logic        i_req_wr,
   input wire logic        i_req_idx,
   input wire logic [31:0] i_req_wdata,
   input wire logic [31:0] o_rdata,
   input wire logic        o_rvalid,
   input wire logic        o_thermal_irq
);
   logic [13:0] pins;
   logic [13:0] pin_q;
   logic [2:0]  quiet_cnt;
   logic        st_rd;
   logic        ext_now;
   assign pins = {i_hot, i_ext_hot, i_forced_power_reduction_input, i_bidir_hot_en, i_crit,
                  i_below_req, i_readout_valid, i_readout};
   assign st_rd = i_ce && i_req_valid && !i_req_wr && !i_req_idx;
   assign ext_now = (i_ext_hot && i_bidir_hot_en) || i_forced_power_reduction_input;
   // Pins must sit still long enough to pass the synchronisers before a read is judged
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         pin_q     <= '0;
         quiet_cnt <= 3'h0;
      end else if (i_ce) begin
         pin_q     <= pins;
         quiet_cnt <= (pin_q != pins) ? 3'h0 : quiet_cnt + {2'h0, quiet_cnt != 3'h7};
      end
   end
   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (!i_rst_n);
   hot_mirror_a: assert property (st_rd && quiet_cnt > 3'h3 |=> o_rdata[0] == $past(i_hot))
      else $error("hot bit differs from pin");
   ext_mirror_a: assert property (st_rd && quiet_cnt > 3'h3 |=> o_rdata[2] == $past(ext_now))
      else $error("external bit differs from pins");
   crit_mirror_a: assert property (st_rd && quiet_cnt > 3'h3 |=> o_rdata[4] == $past(i_crit))
      else $error("critical bit differs from pin");
   below_mirror_a: assert property (st_rd && quiet_cnt > 3'h3
      |=> o_rdata[10] == (PWR_NOTIFY_SUPPORTED && $past(i_below_req))) else $error("power bit wrong");
   readout_field_a: assert property (st_rd && quiet_cnt > 3'h3
      |=> o_rdata[22:16] == ($past(i_readout_valid) ? $past(i_readout) : 7'h00))
      else $error("readout field wrong");
   valid_flag_a: assert property (st_rd && quiet_cnt > 3'h3
      |=> o_rdata[31] == $past(i_readout_valid)) else $error("valid flag wrong");
   resolution_field_a: assert property (st_rd |=> o_rdata[30:27] == SENSOR_RESOLUTION)
      else $error("resolution field wrong");
   ctrl_readback_a: assert property (i_ce && i_req_valid && i_req_wr && i_req_idx
      ##1 !i_req_valid ##1 i_ce && i_req_valid && !i_req_wr && i_req_idx
      |=> o_rvalid && o_rdata == ($past(i_req_wdata, 3) & CTS_CTRL_MASK))
      else $error("control readback wrong");
endmodule : cts_core_sva

bind cts_core cts_core_sva #(
   .PWR_NOTIFY_SUPPORTED(PWR_NOTIFY_SUPPORTED),
   .SENSOR_RESOLUTION   (SENSOR_RESOLUTION)
) cts_core_sva_inst (
   .i_sys_clk, .i_rst_n, .i_ce, .i_hot, .i_ext_hot, .i_forced_power_reduction_input,
   .i_bidir_hot_en, .i_crit, .i_below_req, .i_readout_valid, .i_readout, .i_req_valid,
   .i_req_wr, .i_req_idx, .i_req_wdata, .o_rdata, .o_rvalid, .o_thermal_irq
);

/* File: sim/cts_core_tb.sv */
// Self-checking bench for the core thermal status block
`timescale 1ns/1ps
module cts_core_tb
   import cts_pkg::*;
;
   localparam logic [31:0] RES = 32'h0800_0000;
   logic        i_sys_clk, i_rst_n, ce, bidir, req_valid, req_wr, req_idx, o_rvalid, o_irq;
   logic [31:0] req_wdata, o_rdata, rd;
   cts_sense_t  cmd, pins;
   int          miscompares, check_count;

   cts_core cts_core_inst (.i_sys_clk, .i_rst_n, .i_ce(ce), .i_hot(pins.hot),
      .i_ext_hot(pins.ext_hot), .i_forced_power_reduction_input(pins.forced_power_reduction_input),
      .i_bidir_hot_en(bidir), .i_crit(pins.crit), .i_below_req(pins.below_req),
      .i_readout_valid(pins.valid), .i_readout(pins.readout), .i_req_valid(req_valid),
      .i_req_wr(req_wr), .i_req_idx(req_idx), .i_req_wdata(req_wdata), .o_rdata, .o_rvalid,
      .o_thermal_irq(o_irq));
   cts_agent cts_agent_inst (.i_sys_clk, .i_cmd(cmd), .o_pins(pins));

   initial begin
      i_sys_clk = 1'b0;
      forever #12.5 i_sys_clk = ~i_sys_clk;
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         miscompares++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic complete_run();
      $display("Checks %0d, mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : complete_run

   // One request, held over its taking edge, then a bounded wait for the answer
   task automatic bus(input logic wr, input logic idx, input logic [31:0] wd);
      int n;
      @(negedge i_sys_clk);
      {req_valid, req_wr, req_idx, req_wdata} = {1'b1, wr, idx, wd};
      @(negedge i_sys_clk);
      req_valid = 1'b0;
      for (n = 0; n < 4 && o_rvalid !== 1'b1; n++) @(posedge i_sys_clk) #1;
      if (n == 4) begin
         miscompares++;
         complete_run();
      end
      rd = o_rdata;
   endtask : bus

   task automatic rd_chk(input logic idx, input logic [31:0] exp);
      bus(1'b0, idx, 32'h0);
      chk(rd, exp);
   endtask : rd_chk

   task automatic wait_irq(input logic exp);
      logic seen;
      seen = 1'b0;
      repeat (8) @(posedge i_sys_clk) #1 seen |= (o_irq === 1'b1);
      chk({31'h0, seen}, {31'h0, exp});
   endtask : wait_irq

   // Quiet pins, clear logs, program control, then apply one pin pattern
   task automatic ev(input logic [31:0] ctl, input cts_sense_t p, input logic irq,
                     input logic [31:0] st);
      cmd = '0;
      repeat (6) @(negedge i_sys_clk);
      bus(1'b1, 1'b0, 32'h0);
      bus(1'b1, 1'b1, ctl);
      rd_chk(1'b1, ctl & CTS_CTRL_MASK);
      cmd = p;
      wait_irq(irq);
      rd_chk(1'b0, st);
   endtask : ev

   task automatic t_hot();
      rd_chk(1'b0, RES);
      rd_chk(1'b1, 32'h0);
      ev(32'h0, 13'h1000, 1'b0, RES | 32'h3);
      ev(32'h3, 13'h1000, 1'b1, RES | 32'h3);
      cmd = '0;
      wait_irq(1'b1);
      bus(1'b1, 1'b0, 32'hffff_ffff);
      rd_chk(1'b0, RES | 32'h2);
      bus(1'b1, 1'b0, 32'h0);
      rd_chk(1'b0, RES);
      $display("hot test done");
   endtask : t_hot

   task automatic t_ext();
      ev(32'h4, 13'h0800, 1'b0, RES);
      @(negedge i_sys_clk) bidir = 1'b1;
      ev(32'h4, 13'h0800, 1'b1, RES | 32'hc);
      ev(32'h8, 13'h0400, 1'b1, RES | 32'hc);
      ev(32'h10, 13'h0200, 1'b1, RES | 32'h30);
      ev(32'h0100_0000, 13'h0100, 1'b1, RES | 32'hc00);
      $display("event test done");
   endtask : t_ext

   task automatic t_thr();
      ev(32'h008a_9400, 13'h009e, 1'b0, 32'h881e_0000);
      ev(32'h008a_9400, 13'h0094, 1'b1, 32'h8814_00c0);
      ev(32'h008a_1400, 13'h0089, 1'b1, 32'h8809_03c0);
      $display("threshold test done");
   endtask : t_thr

   // Frozen block must neither log nor signal until the enable returns
   task automatic t_ce();
      ev(32'h1, 13'h0000, 1'b0, RES);
      @(negedge i_sys_clk) ce = 1'b0;
      cmd = 13'h1000;
      wait_irq(1'b0);
      @(negedge i_sys_clk) ce = 1'b1;
      wait_irq(1'b1);
      rd_chk(1'b0, RES | 32'h3);
      $display("clock enable test done");
   endtask : t_ce

   initial begin
      {i_rst_n, bidir, req_valid, req_wr, req_idx, req_wdata, cmd} = '0;
      {miscompares, check_count} = '0;
      ce = 1'b1;
      repeat (10) @(negedge i_sys_clk);
      i_rst_n = 1'b1;
      t_hot();
      t_ext();
      t_thr();
      t_ce();
      complete_run();
   end
endmodule : cts_core_tb
